//--- rtl/sideband_pkg.sv
// Purpose : shared constants for the dma sideband streams and interrupt logic
// Assumes : 32-bit stream words, five user words per descriptor
// Notes   : register map is reached over apb, one aligned word each
package sideband_pkg;

  localparam int DATA_W = 32;
  localparam int USER_N = 5;
  localparam int LEN_W  = 23;
  localparam int IDX_W  = 3;
  localparam int NCH    = 2;
  localparam int CH_TX  = 0;
  localparam int CH_RX  = 1;

  // first control word carries the type tag in its top nibble
  localparam logic [3:0]  CTRL_TAG   = 4'ha;
  localparam int          TAG_LSB    = 28;
  localparam logic [IDX_W-1:0] LAST_IDX = 3'h4;

  // register byte addresses
  localparam logic [7:0] TX_CR_ADDR = 8'h00;
  localparam logic [7:0] TX_SR_ADDR = 8'h04;
  localparam logic [7:0] RX_CR_ADDR = 8'h30;
  localparam logic [7:0] RX_SR_ADDR = 8'h34;

  // field positions, same in control and status registers
  localparam int IOC_BIT = 12;
  localparam int DLY_BIT = 13;
  localparam int ERR_BIT = 14;
  localparam int THR_LSB = 16;
  localparam int DLY_LSB = 24;
  localparam int FLD_W   = 8;

  localparam logic [FLD_W-1:0] THR_RESET = 8'h01;
  localparam logic [FLD_W-1:0] DLY_RESET = 8'h00;
  localparam logic [FLD_W-1:0] CNT_ONE   = 8'h01;
  localparam logic [FLD_W-1:0] CNT_ZERO  = 8'h00;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_TAG  = 3'b010,
    CS_USER = 3'b100
  } ctrl_state_t;

endpackage

//--- rtl/sideband_if.sv
// Purpose : control and status streams between dma and stream peripheral
// Assumes : both ends on pclk
// Notes   : axi4-stream style valid/ready handshakes
`timescale 1ns/1ps
interface sideband_if;
  import sideband_pkg::*;
  logic              ctrl_tvalid;
  logic              ctrl_tready;
  logic [DATA_W-1:0] ctrl_tdata;
  logic              ctrl_tlast;
  logic              sts_tvalid;
  logic              sts_tready;
  logic [DATA_W-1:0] sts_tdata;
  logic              sts_tlast;

  modport dev (output ctrl_tvalid, ctrl_tdata, ctrl_tlast, sts_tready,
               input  ctrl_tready, sts_tvalid, sts_tdata, sts_tlast);
  modport per (input  ctrl_tvalid, ctrl_tdata, ctrl_tlast, sts_tready,
               output ctrl_tready, sts_tvalid, sts_tdata, sts_tlast);
endinterface

//--- rtl/dma_sideband.sv
// Purpose : dma end of the sideband streams plus interrupt coalescing
// Assumes : descriptor engine drives the tx/rx descriptor ports
// Notes   : apb slave, zero wait states, pslverr on unmapped address
//
// Overview of operation
// - sof descriptor starts packet, resets realigner
// - sof user fields go out on control
// - later descriptor user fields are ignored
// - no user field fetch without sideband streams
// - control words independent of data order
// - only peripheral ready may stall control stream
// - first control word carries tag 0xa
// - mark first and last receive buffers
// - software provides enough receive buffer space
// - status words written to last descriptor
// - write bytes received per buffer
// - status ready low while status store full
// - status length feeds receive command
// - stream stalls back-pressure descriptor side
// - interconnect fifo exceeds burst times issuing
// - irq on threshold, delay, error if enabled
// - simple mode irq on each completion
// - completion decrements counter, zero sets flag
// - reload counter on irq, delay, write
// - counter value readable in status register
// - threshold resets to one
// - delay timer runs after eof, clears sof
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module dma_sideband
  import sideband_pkg::*;
#(
  parameter bit sideband_streams_present = 1'b1,
  parameter bit status_length_enable     = 1'b1,
  parameter bit descriptor_mode_present  = 1'b1
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [DATA_W-1:0]        pwdata,
  output logic      [DATA_W-1:0]        prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     tx_desc_valid,
  output logic                          tx_desc_ready,
  input  wire logic                     tx_desc_sof,
  input  wire logic                     tx_desc_eof,
  input  wire logic [USER_N*DATA_W-1:0] tx_desc_user,
  output logic                          tx_dre_reset,
  output logic                          user_fetch_enable,
  input  wire logic                     rx_desc_valid,
  output logic                          rx_desc_ready,
  input  wire logic                     rx_desc_eof,
  input  wire logic [LEN_W-1:0]         rx_desc_bytes,
  output logic                          wb_valid,
  output logic                          wb_first,
  output logic                          wb_last,
  output logic      [LEN_W-1:0]         wb_bytes,
  output logic      [USER_N*DATA_W-1:0] wb_user,
  output logic      [LEN_W-1:0]         rx_len,
  output logic                          rx_len_valid,
  input  wire logic                     tx_error,
  input  wire logic                     rx_error,
  output logic                          tx_channel_irq_out,
  output logic                          rx_channel_irq_out,
  sideband_if.dev                       sb
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  wire logic wr_en = psel & penable & pwrite & clk_en;
  wire logic hit_tx_cr = is_reg(paddr, TX_CR_ADDR);
  wire logic hit_tx_sr = is_reg(paddr, TX_SR_ADDR);
  wire logic hit_rx_cr = is_reg(paddr, RX_CR_ADDR);
  wire logic hit_rx_sr = is_reg(paddr, RX_SR_ADDR);
  wire logic mapped = hit_tx_cr | hit_tx_sr | hit_rx_cr | hit_rx_sr;
  wire logic [NCH-1:0] wr_cr = {wr_en & hit_rx_cr, wr_en & hit_tx_cr};
  wire logic [NCH-1:0] wr_sr = {wr_en & hit_rx_sr, wr_en & hit_tx_sr};

  // per-channel control and state
  logic [FLD_W-1:0] thr_r [NCH];
  logic [FLD_W-1:0] dly_r [NCH];
  logic [2:0]       en_r  [NCH];
  logic [2:0]       flg_r [NCH];
  logic [FLD_W-1:0] cnt_r [NCH];
  logic [FLD_W-1:0] tmr_r [NCH];
  logic [NCH-1:0]   run_r;

  function automatic logic [DATA_W-1:0] cr_word(input int c);
    cr_word = '0;
    cr_word[IOC_BIT +: 3]     = en_r[c];
    cr_word[THR_LSB +: FLD_W] = thr_r[c];
    cr_word[DLY_LSB +: FLD_W] = dly_r[c];
  endfunction

  function automatic logic [DATA_W-1:0] sr_word(input int c);
    sr_word = '0;
    sr_word[IOC_BIT +: 3]     = flg_r[c];
    sr_word[THR_LSB +: FLD_W] = cnt_r[c];
    sr_word[DLY_LSB +: FLD_W] = tmr_r[c];
  endfunction

  // read mux, zero-wait answer
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = hit_tx_cr ? cr_word(CH_TX) :
                   hit_tx_sr ? sr_word(CH_TX) :
                   hit_rx_cr ? cr_word(CH_RX) :
                   hit_rx_sr ? sr_word(CH_RX) : '0;

  // ---------------------------------------------------------------
  // control stream (tx)
  // ---------------------------------------------------------------
  ctrl_state_t        cs_r;
  logic [IDX_W-1:0]   cidx_r;
  logic [DATA_W-1:0]  cbuf_r [USER_N];
  logic [DATA_W-1:0]  ctag_r;

  wire logic ctrl_busy = (cs_r != CS_IDLE);
  wire logic ctrl_beat = sb.ctrl_tvalid & sb.ctrl_tready;
  // a new sof waits until the previous control packet drained
  wire logic tx_stall  = tx_desc_sof & sideband_streams_present & ctrl_busy;
  assign tx_desc_ready = ~tx_stall;
  wire logic tx_take   = tx_desc_valid & tx_desc_ready & clk_en;
  wire logic tx_sof_ev = tx_take & tx_desc_sof;
  wire logic tx_done   = tx_take & tx_desc_eof;

  // user words fetched only when the streams exist
  assign user_fetch_enable = sideband_streams_present;
  // realigner reset pulse on packet start
  assign tx_dre_reset = tx_sof_ev;

  // control words go out on their own pace, not tied to data
  assign sb.ctrl_tvalid = ctrl_busy;
  assign sb.ctrl_tdata  = (cs_r == CS_TAG) ? ctag_r : cbuf_r[cidx_r];
  assign sb.ctrl_tlast  = (cs_r == CS_USER) & (cidx_r == LAST_IDX);

  // control packet sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_r   <= CS_IDLE;
      cidx_r <= '0;
      ctag_r <= '0;
    end else if (clk_en) begin
      unique case (cs_r)
        CS_IDLE: begin
          // sof user fields queued for the control stream
          if (tx_sof_ev && sideband_streams_present) begin
            cs_r   <= CS_TAG;
            cidx_r <= '0;
            ctag_r <= {CTRL_TAG, {TAG_LSB{1'b0}}};
          end
        end
        CS_TAG: begin
          if (ctrl_beat) cs_r <= CS_USER;
        end
        CS_USER: begin
          if (ctrl_beat) begin
            if (cidx_r == LAST_IDX) cs_r <= CS_IDLE;
            cidx_r <= (cidx_r == LAST_IDX) ? '0 : cidx_r + 3'h1;
          end
        end
      endcase
    end
  end

  // only the sof descriptor loads user words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < USER_N; i++) cbuf_r[i] <= '0;
    end else if (clk_en && tx_sof_ev && !ctrl_busy) begin
      for (int i = 0; i < USER_N; i++)
        cbuf_r[i] <= tx_desc_user[i*DATA_W +: DATA_W];
    end
  end

  // ---------------------------------------------------------------
  // status stream (rx)
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] sbuf_r [USER_N];
  logic [IDX_W-1:0]  sidx_r;
  logic              sfull_r;
  logic              in_pkt_r;

  // status ready drops while the store holds a packet
  assign sb.sts_tready = ~sfull_r;
  wire logic sts_beat = sb.sts_tvalid & sb.sts_tready & clk_en;
  wire logic sts_end  = sb.sts_tlast | (sidx_r == LAST_IDX);
  // eof descriptor waits for its status
  assign rx_desc_ready = ~(rx_desc_eof & sideband_streams_present & ~sfull_r);
  wire logic rx_take = rx_desc_valid & rx_desc_ready & clk_en;
  wire logic rx_done = rx_take & rx_desc_eof;
  wire logic rx_sof_ev = rx_take & ~in_pkt_r;

  // length from last status word drives the receive command
  assign rx_len       = sbuf_r[USER_N-1][LEN_W-1:0];
  assign rx_len_valid = status_length_enable & sfull_r;

  // status capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < USER_N; i++) sbuf_r[i] <= '0;
      sidx_r  <= '0;
      sfull_r <= 1'b0;
    end else if (clk_en) begin
      if (sts_beat) begin
        sbuf_r[sidx_r] <= sb.sts_tdata;
        sidx_r <= sts_end ? '0 : sidx_r + 3'h1;
        if (sts_end) sfull_r <= 1'b1;
      end else if (rx_done) begin
        sfull_r <= 1'b0;
      end
    end
  end

  // descriptor write-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_pkt_r <= 1'b0;
      wb_valid <= 1'b0;
      wb_first <= 1'b0;
      wb_last  <= 1'b0;
      wb_bytes <= '0;
      wb_user  <= '0;
    end else if (clk_en) begin
      wb_valid <= rx_take;
      if (rx_take) begin
        in_pkt_r <= ~rx_desc_eof;
        wb_first <= ~in_pkt_r;
        wb_last  <= rx_desc_eof;
        wb_bytes <= rx_desc_bytes;
        // status words into the last descriptor
        if (rx_desc_eof && sideband_streams_present)
          for (int i = 0; i < USER_N; i++)
            wb_user[i*DATA_W +: DATA_W] <= sbuf_r[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt coalescing and delay timer
  // ---------------------------------------------------------------
  wire logic [NCH-1:0] done_ev = {rx_done, tx_done};
  wire logic [NCH-1:0] sof_ev  = {rx_sof_ev, tx_sof_ev};
  wire logic [NCH-1:0] err_ev  = {rx_error, tx_error};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        thr_r[c] <= THR_RESET;
        cnt_r[c] <= THR_RESET;
        dly_r[c] <= DLY_RESET;
        en_r[c]  <= '0;
        flg_r[c] <= '0;
        tmr_r[c] <= CNT_ZERO;
      end
      run_r <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < NCH; c++) begin
        automatic logic [FLD_W-1:0] lim;
        automatic logic dly_on, dly_hit, thr_hit;
        automatic logic [2:0] set, clr;
        lim     = (thr_r[c] == CNT_ZERO) ? CNT_ONE : thr_r[c];
        dly_on  = descriptor_mode_present && (dly_r[c] != CNT_ZERO);
        dly_hit = dly_on && run_r[c] && (tmr_r[c] == dly_r[c]);
        thr_hit = done_ev[c] && (cnt_r[c] <= CNT_ONE);
        set = '0;
        set[0] = descriptor_mode_present ? thr_hit : done_ev[c];
        set[1] = dly_hit;
        set[2] = err_ev[c];
        clr = wr_sr[c] ? pwdata[IOC_BIT +: 3] : 3'h0;
        // hardware set wins over software clear
        flg_r[c] <= (flg_r[c] & ~clr) | set;
        if (wr_cr[c]) begin
          en_r[c]  <= pwdata[IOC_BIT +: 3];
          thr_r[c] <= pwdata[THR_LSB +: FLD_W];
          dly_r[c] <= pwdata[DLY_LSB +: FLD_W];
        end
        // reload on write, threshold hit or delay hit
        if (wr_cr[c])
          cnt_r[c] <= (pwdata[THR_LSB +: FLD_W] == CNT_ZERO) ?
                      CNT_ONE : pwdata[THR_LSB +: FLD_W];
        else if (thr_hit || dly_hit)
          cnt_r[c] <= lim;
        else if (done_ev[c])
          cnt_r[c] <= cnt_r[c] - CNT_ONE;
        // timer runs after eof, cleared by sof, parked after hit
        // a one-descriptor packet is sof and eof: its eof still starts it
        if (dly_hit || !dly_on) begin
          run_r[c] <= 1'b0;
          tmr_r[c] <= CNT_ZERO;
        end else if (done_ev[c] && !flg_r[c][1]) begin
          run_r[c] <= 1'b1;
          tmr_r[c] <= CNT_ZERO;
        end else if (sof_ev[c]) begin
          run_r[c] <= 1'b0;
          tmr_r[c] <= CNT_ZERO;
        end else if (run_r[c]) begin
          tmr_r[c] <= tmr_r[c] + CNT_ONE;
        end
      end
    end
  end

  // enabled flags drive each channel output
  assign tx_channel_irq_out = |(flg_r[CH_TX] & en_r[CH_TX]);
  assign rx_channel_irq_out = |(flg_r[CH_RX] & en_r[CH_RX]);

endmodule

//--- rtl/stream_peripheral.sv
// Purpose : peripheral end: takes control words, sends status words
// Assumes : user side decides when to stall and what status to send
// Notes   : status packets are always five words, last one flagged
`timescale 1ns/1ps
module stream_peripheral
  import sideband_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  input  wire logic                     ctrl_accept,
  output logic                          ctrl_word_valid,
  output logic      [DATA_W-1:0]        ctrl_word,
  output logic                          ctrl_word_last,
  input  wire logic                     sts_load,
  input  wire logic [USER_N*DATA_W-1:0] sts_words,
  input  wire logic                     sts_pause,
  output logic                          sts_busy,
  sideband_if.per                       sb
);

  logic [DATA_W-1:0] sbuf_r [USER_N];
  logic [IDX_W-1:0]  sidx_r;

  // control ready follows the user accept input
  assign sb.ctrl_tready = ctrl_accept;
  wire logic ctrl_beat  = sb.ctrl_tvalid & sb.ctrl_tready & clk_en;

  // capture each control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_word_valid <= 1'b0;
      ctrl_word       <= '0;
      ctrl_word_last  <= 1'b0;
    end else if (clk_en) begin
      ctrl_word_valid <= ctrl_beat;
      if (ctrl_beat) begin
        ctrl_word      <= sb.ctrl_tdata;
        ctrl_word_last <= sb.ctrl_tlast;
      end
    end
  end

  // status source may pause its valid
  assign sb.sts_tvalid = sts_busy & ~sts_pause;
  assign sb.sts_tdata  = sbuf_r[sidx_r];
  assign sb.sts_tlast  = (sidx_r == LAST_IDX);
  wire logic sts_beat  = sb.sts_tvalid & sb.sts_tready & clk_en;

  // status packet sender
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < USER_N; i++) sbuf_r[i] <= '0;
      sidx_r   <= '0;
      sts_busy <= 1'b0;
    end else if (clk_en) begin
      if (!sts_busy && sts_load) begin
        for (int i = 0; i < USER_N; i++)
          sbuf_r[i] <= sts_words[i*DATA_W +: DATA_W];
        sidx_r   <= '0;
        sts_busy <= 1'b1;
      end else if (sts_beat) begin
        sidx_r <= (sidx_r == LAST_IDX) ? '0 : sidx_r + 3'h1;
        if (sidx_r == LAST_IDX) sts_busy <= 1'b0;
      end
    end
  end

endmodule

//--- verif/sideband_monitor.sv
// Purpose : stream protocol checks between dma end and peripheral end
// Assumes : one clock domain, asynchronous active-low reset
// Notes   : control packets are six beats, status packets five
`timescale 1ns/1ps
module sideband_monitor
  import sideband_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ctrl_tvalid,
  input wire logic              ctrl_tready,
  input wire logic [DATA_W-1:0] ctrl_tdata,
  input wire logic              ctrl_tlast,
  input wire logic              sts_tvalid,
  input wire logic              sts_tready,
  input wire logic [DATA_W-1:0] sts_tdata,
  input wire logic              sts_tlast
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // beat counters
  // ------------------------------------------------------------
  logic [2:0] beat_r, beat_nxt, sts_r, sts_nxt;
  wire        ctrl_hs = ctrl_tvalid & ctrl_tready;
  wire        sts_hs  = sts_tvalid & sts_tready;
  wire        sts_end = sts_hs & (sts_tlast | (sts_r == 3'h4));
  // count accepted beats, restart after each packet
  assign beat_nxt = ctrl_hs ? (ctrl_tlast ? 3'h0 : beat_r + 3'h1) : beat_r;
  assign sts_nxt  = sts_end ? 3'h0 : (sts_hs ? sts_r + 3'h1 : sts_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_r <= 3'h0;
      sts_r  <= 3'h0;
    end else begin
      beat_r <= beat_nxt;
      sts_r  <= sts_nxt;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_ctrl_hold: assert property (
    ctrl_tvalid && !ctrl_tready |=> ctrl_tvalid)
    else $error("control valid dropped unaccepted");
  chk_ctrl_stable: assert property (
    ctrl_tvalid && !ctrl_tready |=> $stable(ctrl_tdata) && $stable(ctrl_tlast))
    else $error("control word changed while stalled");
  chk_ctrl_drop: assert property (
    $fell(ctrl_tvalid) |-> $past(ctrl_tready))
    else $error("control valid fell without accept");
  chk_tag_first: assert property (
    ctrl_tvalid && beat_r == 3'h0 |-> ctrl_tdata[DATA_W-1 -: 4] == CTRL_TAG)
    else $error("first control word lacks type tag");
  chk_last_sixth: assert property (
    ctrl_hs && ctrl_tlast |-> beat_r == 3'h5)
    else $error("control last not on sixth beat");
  chk_sixth_last: assert property (
    ctrl_hs && beat_r == 3'h5 |-> ctrl_tlast)
    else $error("sixth control beat without last");
  chk_ctrl_gap: assert property (
    ctrl_hs && ctrl_tlast |-> ##1 !ctrl_tvalid)
    else $error("control valid after packet end");
  chk_sts_full: assert property (
    sts_end |=> !sts_tready)
    else $error("status ready high with store full");
endmodule

//--- verif/tb_dma_sideband.sv
// Purpose : self-checking bench for both ends of the sideband streams
// Assumes : ends joined by one sideband_if, pclk at 100 MHz
// Notes   : registers reached over apb, zero-wait slave
`timescale 1ns/1ps
module tb_dma_sideband;
  import sideband_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic tx_desc_valid, tx_desc_ready, tx_desc_sof, tx_desc_eof;
  logic tx_dre_reset, user_fetch_enable, rx_desc_valid, rx_desc_ready;
  logic rx_desc_eof, wb_valid, wb_first, wb_last, rx_len_valid;
  logic tx_error, rx_error, tx_channel_irq_out, rx_channel_irq_out;
  logic ctrl_accept, ctrl_word_valid, ctrl_word_last, sts_load, sts_pause;
  logic sts_busy, last_err, dre_seen;
  logic [7:0]               paddr;
  logic [1:0]               cyc;
  logic [DATA_W-1:0]        pwdata, prdata, rdat, ctrl_word;
  logic [DATA_W:0]          ew;
  logic [DATA_W:0]          cq[$];
  logic [LEN_W-1:0]         rx_desc_bytes, wb_bytes, rx_len;
  logic [USER_N*DATA_W-1:0] tx_desc_user, wb_user, sts_words, ua, ub, sw;
  int                       n_mismatch = 0;
  int                       check_count = 0;

  sideband_if u_sideband_if ();
  dma_sideband u_dma_sideband (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_desc_valid, .tx_desc_ready,
    .tx_desc_sof, .tx_desc_eof, .tx_desc_user, .tx_dre_reset,
    .user_fetch_enable, .rx_desc_valid, .rx_desc_ready, .rx_desc_eof,
    .rx_desc_bytes, .wb_valid, .wb_first, .wb_last, .wb_bytes, .wb_user,
    .rx_len, .rx_len_valid, .tx_error, .rx_error, .tx_channel_irq_out,
    .rx_channel_irq_out, .sb(u_sideband_if));
  stream_peripheral u_stream_peripheral (
    .pclk, .presetn, .clk_en, .ctrl_accept, .ctrl_word_valid, .ctrl_word,
    .ctrl_word_last, .sts_load, .sts_words, .sts_pause, .sts_busy,
    .sb(u_sideband_if));
  sideband_monitor u_sideband_monitor (
    .pclk, .presetn, .ctrl_tvalid(u_sideband_if.ctrl_tvalid),
    .ctrl_tready(u_sideband_if.ctrl_tready),
    .ctrl_tdata(u_sideband_if.ctrl_tdata),
    .ctrl_tlast(u_sideband_if.ctrl_tlast),
    .sts_tvalid(u_sideband_if.sts_tvalid),
    .sts_tready(u_sideband_if.sts_tready),
    .sts_tdata(u_sideband_if.sts_tdata),
    .sts_tlast(u_sideband_if.sts_tlast));

  // ------------------------------------------------------------
  // clock, stall pattern, control word capture
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // peripheral refuses one beat in four
  always @(posedge pclk) begin
    cyc         <= cyc + 2'h1;
    ctrl_accept <= cyc != 2'h0;
    if (ctrl_word_valid === 1'b1) begin
      cq.push_back({ctrl_word_last, ctrl_word});
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, read data left in rdat
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tx_d(input logic s, input logic e,
                      input logic [USER_N*DATA_W-1:0] u);
    @(posedge pclk);
    tx_desc_valid <= 1'b1;
    tx_desc_sof   <= s;
    tx_desc_eof   <= e;
    tx_desc_user  <= u;
    do @(posedge pclk); while (tx_desc_ready !== 1'b1);
    dre_seen = tx_dre_reset;
    tx_desc_valid <= 1'b0;
  endtask
  task automatic rx_d(input logic e, input logic [LEN_W-1:0] b);
    @(posedge pclk);
    rx_desc_valid <= 1'b1;
    rx_desc_eof   <= e;
    rx_desc_bytes <= b;
    do @(posedge pclk); while (rx_desc_ready !== 1'b1);
    rx_desc_valid <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cyc} = '0;
    {tx_desc_valid, tx_desc_sof, tx_desc_eof, tx_desc_user} = '0;
    {rx_desc_valid, rx_desc_eof, rx_desc_bytes, tx_error, rx_error} = '0;
    {ctrl_accept, sts_load, sts_words, sts_pause} = '0;
    clk_en = 1'b1;
    for (int i = 0; i < USER_N; i++) begin
      ua[32*i +: 32] = 32'hc0de_0000 + 32'(i);
      ub[32*i +: 32] = 32'h0bad_0000 + 32'(i);
      sw[32*i +: 32] = 32'h5700_0010 + 32'(i);
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TX_CR_ADDR, 32'h0);
    chk(rdat, 32'h0001_0000);
    apb(1'b0, TX_SR_ADDR, 32'h0);
    chk(rdat, 32'h0001_0000);
    chk(user_fetch_enable, 1'b1);
    apb(1'b0, 8'h80, 32'h0);
    chk({last_err, rdat}, {1'b1, 32'h0});
    $display("test reset done");
    apb(1'b1, TX_CR_ADDR, 32'h0001_1000);
    tx_d(1'b1, 1'b0, ua);
    chk(dre_seen, 1'b1);
    tx_d(1'b0, 1'b0, ub);
    chk(dre_seen, 1'b0);
    tx_d(1'b0, 1'b1, ub);
    repeat (30) @(posedge pclk);
    chk(cq.size(), 6);
    for (int i = 0; i < 6; i++) begin
      ew = (i == 0) ? {1'b0, CTRL_TAG, 28'h0} : {i == 5, ua[32*i-32 +: 32]};
      chk(cq[i], ew);
    end
    chk(tx_channel_irq_out, 1'b1);
    apb(1'b1, TX_SR_ADDR, 32'h0000_1000);
    repeat (2) @(posedge pclk);
    chk(tx_channel_irq_out, 1'b0);
    $display("test control stream done");
    apb(1'b1, TX_CR_ADDR, 32'h0003_1000);
    apb(1'b0, TX_SR_ADDR, 32'h0);
    chk(rdat, 32'h0003_0000);
    repeat (2) tx_d(1'b0, 1'b1, ub);
    apb(1'b0, TX_SR_ADDR, 32'h0);
    chk(rdat, 32'h0001_0000);
    chk(tx_channel_irq_out, 1'b0);
    tx_d(1'b0, 1'b1, ub);
    repeat (2) @(posedge pclk);
    chk(tx_channel_irq_out, 1'b1);
    apb(1'b0, TX_SR_ADDR, 32'h0);
    chk(rdat, 32'h0003_1000);
    apb(1'b1, TX_SR_ADDR, 32'h0000_1000);
    $display("test coalescing done");
    apb(1'b1, TX_CR_ADDR, 32'h0001_4000);
    tx_error <= 1'b1;
    @(posedge pclk);
    tx_error <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(tx_channel_irq_out, 1'b1);
    apb(1'b1, TX_SR_ADDR, 32'h0000_4000);
    repeat (2) @(posedge pclk);
    chk(tx_channel_irq_out, 1'b0);
    $display("test error irq done");
    apb(1'b1, RX_CR_ADDR, 32'h0405_3000);
    sts_words <= sw;
    sts_pause <= 1'b1;
    sts_load  <= 1'b1;
    @(posedge pclk);
    sts_load <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(sts_busy, 1'b1);
    sts_pause <= 1'b0;
    while (rx_len_valid !== 1'b1) @(posedge pclk);
    chk(rx_len, sw[4*32 +: LEN_W]);
    chk(sts_busy, 1'b0);
    rx_d(1'b0, 23'd100);
    chk({wb_valid, wb_first, wb_last, wb_bytes}, {3'b110, 23'd100});
    chk(u_sideband_if.sts_tready, 1'b0);
    rx_d(1'b1, 23'd20);
    chk({wb_valid, wb_first, wb_last, wb_bytes}, {3'b101, 23'd20});
    chk(wb_user, sw);
    repeat (12) @(posedge pclk);
    chk(rx_channel_irq_out, 1'b1);
    apb(1'b0, RX_SR_ADDR, 32'h0);
    chk(rdat, 32'h0005_2000);
    apb(1'b1, RX_SR_ADDR, 32'h0000_2000);
    repeat (2) @(posedge pclk);
    chk(rx_channel_irq_out, 1'b0);
    clk_en <= 1'b0;
    apb(1'b1, RX_CR_ADDR, 32'h0);
    clk_en <= 1'b1;
    apb(1'b0, RX_CR_ADDR, 32'h0);
    chk(rdat, 32'h0405_3000);
    $display("test status stream done");
    wrap_up;
  end
endmodule
